/* shared/fe_pkg.sv */
// Purpose: Shared types and constants for the 100 Mb/s receive coding path
// Assumes: One system clock at 20 MHz, one line bit per sym_valid strobe
// Notes:   Every figure used by more than one file lives here
`default_nettype none

package fe_pkg;

	// ====================================================================
	// Clock and timing
	localparam int CLK_MHZ = 20; // System clock rate
	localparam int HOLD_US = 722; // Descrambler hold countdown
	localparam int HOLD_CYC = HOLD_US * CLK_MHZ; // Countdown in cycles
	localparam int LINK_US = 395; // Signal detect qualification
	localparam int LINK_CYC = LINK_US * CLK_MHZ; // Qualification in cycles
	localparam int SD_QUAL_NS = 2000; // Least energy run counted as signal
	localparam int SD_QUAL_CYC = (SD_QUAL_NS * CLK_MHZ + 999) / 1000; // Rounded up

	// ====================================================================
	// Descrambler
	localparam int SYM_BITS = 5; // Bits per code-group
	localparam int IDLE_SYNC_GROUPS = 12; // Idle groups needed for lock
	localparam logic [6:0] IDLE_SYNC_BITS = 7'(IDLE_SYNC_GROUPS * SYM_BITS);
	localparam logic [6:0] IDLE_HOLD_BITS = 7'h3a; // 58 bit times of idle
	localparam int LFSR_W = 11; // Sequence generator length
	localparam int LFSR_TAP = 8; // Feedback tap two below the top stage

	// ====================================================================
	// Code-groups and nibbles
	localparam logic [4:0] CODE_I = 5'h1f; // Idle
	localparam logic [4:0] CODE_J = 5'h18; // First start delimiter
	localparam logic [4:0] CODE_K = 5'h11; // Second start delimiter
	localparam logic [4:0] CODE_T = 5'h0d; // First end delimiter
	localparam logic [4:0] CODE_R = 5'h07; // Second end delimiter
	localparam logic [9:0] JK_PAIR = 10'h311; // J then K, first bit left
	localparam logic [3:0] PRE_NIB = 4'h5; // Preamble nibble
	localparam logic [3:0] ERR_NIB = 4'he; // Nibble shown with an error
	localparam int FIFO_DEPTH = 32; // Nibble buffer depth

	// ====================================================================
	// Types
	typedef enum logic [1:0] {
		LVL_ZERO = 2'b00,
		LVL_POS = 2'b01,
		LVL_NEG = 2'b11
	} fe_lvl_t; // Three-level line symbol

	typedef struct packed {
		logic er; // Receive error with this nibble
		logic [3:0] nib; // Nibble data
	} fe_nib_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_PRE2 = 2'b01,
		ST_DATA = 2'b10,
		ST_END = 2'b11
	} fe_dec_st_t;

	// Data code-group to nibble, top bit says the group is data
	function automatic logic [4:0] fe_dec5(input logic [4:0] g);
		logic [4:0] r;
		r = 5'h00;
		case (g)
			5'h1e: r = 5'h10;
			5'h09: r = 5'h11;
			5'h14: r = 5'h12;
			5'h15: r = 5'h13;
			5'h0a: r = 5'h14;
			5'h0b: r = 5'h15;
			5'h0e: r = 5'h16;
			5'h0f: r = 5'h17;
			5'h12: r = 5'h18;
			5'h13: r = 5'h19;
			5'h16: r = 5'h1a;
			5'h17: r = 5'h1b;
			5'h1a: r = 5'h1c;
			5'h1b: r = 5'h1d;
			5'h1c: r = 5'h1e;
			5'h1d: r = 5'h1f;
			default: r = 5'h00;
		endcase
		return r;
	endfunction : fe_dec5

endpackage : fe_pkg

`default_nettype wire

/* src/fe_fifo.sv */
// Purpose: Nibble buffer between the decoder and the MII side
// Assumes: Same clock both sides, synchronous active-low reset copy
// Notes:   Read data comes from a register; holds DEPTH plus one words
`default_nettype none

module fe_fifo #(
	parameter int W = 5,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);

	localparam int AW = $clog2(DEPTH);

	// ====================================================================
	// Storage and pointers
	logic [W-1:0] mem [DEPTH]; // Word store
	logic [AW:0] wr_q, wr_d; // Write pointer with wrap bit
	logic [AW:0] rd_q, rd_d; // Read pointer with wrap bit
	logic ov_q, ov_d; // Output register holds a word
	logic [W-1:0] od_q; // Output register
	logic empty; // Store empty
	logic full; // Store full
	logic push; // Word accepted
	logic load; // Output register refilled

	// Flags and pointer moves
	always_comb
	begin
		empty = (wr_q == rd_q);
		full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
		in_ready = !full;
		push = in_valid && !full;
		load = !empty && (!ov_q || out_ready);
		wr_d = push ? wr_q + 1'b1 : wr_q;
		rd_d = load ? rd_q + 1'b1 : rd_q;
		if (load)
			ov_d = 1'b1;
		else if (out_ready)
			ov_d = 1'b0;
		else
			ov_d = ov_q;
	end

	// Registers; reset clears pointers and output register, store content is don't-care
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			wr_q <= '0;
			rd_q <= '0;
			ov_q <= 1'b0;
			od_q <= '0;
		end
		else
		begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			ov_q <= ov_d;
			if (load)
				od_q <= mem[rd_q[AW-1:0]];
		end
	end

	// Memory write port
	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_q[AW-1:0]] <= in_data;
	end

	assign out_valid = ov_q;
	assign out_data = od_q;

endmodule : fe_fifo

`default_nettype wire

/* src/fe_rx_path.sv */
// Purpose: 100 Mb/s receive path from equalized line symbols to MII nibbles
// Assumes: Line symbols arrive on clk with sym_valid, one bit time each
// Notes:   Energy and bypass inputs are pins and are synchronised first
`default_nettype none

// Notes on behaviour
// - Three-level symbols become NRZI bits
// - NRZI change means one, gives NRZ
// - Serial bits grouped into five-bit symbols
// - Local sequence XORed with scrambled bits
// - Twelve idle groups give descrambler lock
// - Lock starts hold timer; 58 idle bits restart
// - Hold expiry drops lock and resets descrambler
// - Aligner fed by descrambler or bypass NRZ
// - J/K pair fixes the five-bit boundary
// - J/K after idle becomes two preamble nibbles
// - Decode until T/R or two idles
// - Link up after 395 us steady detect
// - Link pulses never raise signal detect
// - Eleven-bit closed-loop sequence generator
// - Standard map; unlisted groups invalid
// - Control groups in data flagged with error
module fe_rx_path
	import fe_pkg::*;
#(
	parameter logic [15:0] HOLD_CYC_P = 16'(fe_pkg::HOLD_CYC),
	parameter logic [15:0] LINK_CYC_P = 16'(fe_pkg::LINK_CYC),
	parameter int DEPTH = fe_pkg::FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic sym_valid,
	input wire fe_pkg::fe_lvl_t sym_level,
	input wire logic sig_energy,
	input wire logic descr_bypass,
	input wire logic mii_ready,
	output logic mii_rx_dv,
	output logic [3:0] mii_rxd,
	output logic mii_rx_er,
	output logic rx_active,
	output logic signal_detect,
	output logic link_up,
	output logic tx_pcs_en,
	output logic rx_pcs_en,
	output logic descr_locked,
	output logic rx_overflow
);

	// ====================================================================
	// Reset release and pin synchronisers
	logic rst_meta_q, rst_n; // Reset release pair
	logic sd_meta_q, sd_sync_q; // Energy pin pair
	logic byp_meta_q, byp_sync_q; // Bypass pin pair

	// Async assert, clocked release
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rst_meta_q <= 1'b0;
			rst_n <= 1'b0;
			sd_meta_q <= 1'b0;
			sd_sync_q <= 1'b0;
			byp_meta_q <= 1'b0;
			byp_sync_q <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_n <= rst_meta_q;
			sd_meta_q <= sig_energy;
			sd_sync_q <= sd_meta_q;
			byp_meta_q <= descr_bypass;
			byp_sync_q <= byp_meta_q;
		end
	end

	// ====================================================================
	// Signal detect filter and link monitor
	logic [5:0] sdc_q, sdc_d; // Continuous energy run length
	logic sd_ok_q, sd_ok_d; // Qualified signal detect
	logic [15:0] lnk_q, lnk_d; // Qualification counter
	logic link_q, link_d; // Link up

	// Short bursts such as link pulses never fill the run counter
	always_comb
	begin
		sdc_d = sdc_q;
		sd_ok_d = 1'b0;
		if (!sd_sync_q)
			sdc_d = '0;
		else if (sdc_q != 6'(SD_QUAL_CYC - 1))
			sdc_d = sdc_q + 6'h01;
		else
			sd_ok_d = 1'b1;
		lnk_d = '0;
		link_d = 1'b0;
		if (sd_ok_q)
		begin
			// Counts only while detect holds; any drop restarts it
			link_d = link_q || (lnk_q == LINK_CYC_P - 16'h0001);
			lnk_d = link_d ? lnk_q : lnk_q + 16'h0001;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			sdc_q <= '0;
			sd_ok_q <= 1'b0;
			lnk_q <= '0;
			link_q <= 1'b0;
		end
		else
		begin
			sdc_q <= sdc_d;
			sd_ok_q <= sd_ok_d;
			lnk_q <= lnk_d;
			link_q <= link_d;
		end
	end

	// ====================================================================
	// MLT-3 to NRZI to NRZ
	fe_lvl_t lvl_q, lvl_d; // Last line level
	logic nrzi_q, nrzi_d; // NRZI bit
	logic nrzi_p_q, nrzi_p_d; // Previous NRZI bit
	logic b1_v_q; // NRZ bit valid
	logic nrz; // NRZ bit

	always_comb
	begin
		lvl_d = lvl_q;
		nrzi_d = nrzi_q;
		nrzi_p_d = nrzi_p_q;
		if (sym_valid)
		begin
			lvl_d = sym_level;
			nrzi_d = nrzi_q ^ (sym_level != lvl_q);
			nrzi_p_d = nrzi_q;
		end
		nrz = nrzi_q ^ nrzi_p_q;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			lvl_q <= LVL_ZERO;
			nrzi_q <= 1'b0;
			nrzi_p_q <= 1'b0;
			b1_v_q <= 1'b0;
		end
		else
		begin
			lvl_q <= lvl_d;
			nrzi_q <= nrzi_d;
			nrzi_p_q <= nrzi_p_d;
			b1_v_q <= sym_valid && link_q;
		end
	end

	// ====================================================================
	// Descrambler with idle acquisition and hold timer
	logic [LFSR_W-1:0] lfsr_q, lfsr_d; // Sequence generator
	logic lock_q, lock_d; // Synchronised
	logic [6:0] ones_q, ones_d; // Run of descrambled ones
	logic [15:0] hold_q, hold_d; // Hold countdown
	logic seq; // Sequence bit for this position
	logic ud; // Descrambled bit

	always_comb
	begin
		seq = lfsr_q[LFSR_W-1] ^ lfsr_q[LFSR_TAP];
		ud = nrz ^ seq;
		lfsr_d = lfsr_q;
		lock_d = lock_q;
		ones_d = ones_q;
		hold_d = hold_q;
		if (lock_q)
			hold_d = hold_q - 16'h0001;
		if (b1_v_q)
		begin
			ones_d = ud ? ((ones_q == 7'h7f) ? ones_q : ones_q + 7'h01) : 7'h00;
			if (!lock_q)
			begin
				// Idle is all ones, so the line bit inverted is the sequence
				lfsr_d = {lfsr_q[LFSR_W-2:0], ~nrz};
				if (ud && ones_q == IDLE_SYNC_BITS - 7'h01)
				begin
					lock_d = 1'b1;
					hold_d = HOLD_CYC_P - 16'h0001;
				end
			end
			else
			begin
				lfsr_d = {lfsr_q[LFSR_W-2:0], seq};
				// Any idle bit past the threshold restarts it, so steady idle keeps lock
				if (ud && ones_q >= IDLE_HOLD_BITS - 7'h01)
					hold_d = HOLD_CYC_P - 16'h0001;
			end
		end
		if (lock_q && hold_q == 16'h0000)
		begin
			lock_d = 1'b0;
			lfsr_d = '0;
			ones_d = '0;
			hold_d = '0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n || !link_q)
		begin
			lfsr_q <= '0;
			lock_q <= 1'b0;
			ones_q <= '0;
			hold_q <= '0;
		end
		else
		begin
			lfsr_q <= lfsr_d;
			lock_q <= lock_d;
			ones_q <= ones_d;
			hold_q <= hold_d;
		end
	end

	// ====================================================================
	// Serial to parallel and code-group alignment
	logic [14:0] win_q, win_d; // Last fifteen bits, oldest left; top group is pre-J
	logic [2:0] bc_q, bc_d; // Bit position in group
	logic al_q, al_d; // Boundary fixed by J/K
	logic gv_q, gv_d; // Group strobe
	logic [4:0] grp_q, grp_d; // Latest group
	logic gjk_q, gjk_d; // Group closes a J/K pair
	logic sv; // Selected bit valid
	logic sb; // Selected bit
	logic jk_hit; // J/K seen in the window

	always_comb
	begin
		sv = byp_sync_q ? b1_v_q : (b1_v_q && lock_q);
		sb = byp_sync_q ? nrz : ud;
		win_d = sv ? {win_q[13:0], sb} : win_q;
		jk_hit = sv && (win_d[9:0] == JK_PAIR);
		bc_d = bc_q;
		al_d = al_q || jk_hit;
		gv_d = 1'b0;
		grp_d = grp_q;
		gjk_d = 1'b0;
		if (sv)
		begin
			// Boundary restarts on the pair and then stays fixed
			bc_d = (jk_hit || bc_q == 3'h4) ? 3'h0 : bc_q + 3'h1;
			gv_d = jk_hit || (bc_q == 3'h4);
			grp_d = win_d[4:0];
			// Idle test is bit-exact, so it holds before any boundary is known
			gjk_d = jk_hit && (win_d[14:10] == CODE_I);
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n || !link_q || !(lock_q || byp_sync_q))
		begin
			win_q <= '0;
			bc_q <= '0;
			al_q <= 1'b0;
			gv_q <= 1'b0;
			grp_q <= '0;
			gjk_q <= 1'b0;
		end
		else
		begin
			win_q <= win_d;
			bc_q <= bc_d;
			al_q <= al_d;
			gv_q <= gv_d;
			grp_q <= grp_d;
			gjk_q <= gjk_d;
		end
	end

	// ====================================================================
	// Decoder state machine
	fe_dec_st_t st_q, st_d; // Decoder state
	logic isn_q, isn_d; // Idle seen before the pair
	logic ov_q, ov_d; // Sticky overflow
	logic push_v; // Nibble offered to buffer
	fe_nib_t push_data; // Nibble offered
	logic in_ready; // Buffer has room
	logic [4:0] dcd; // Lookup result
	fe_nib_t out_data; // Buffer head

	always_comb
	begin
		st_d = st_q;
		isn_d = isn_q;
		push_v = 1'b0;
		push_data = '{er: 1'b0, nib: PRE_NIB};
		dcd = fe_dec5(grp_q);
		case (st_q)
			ST_IDLE:
			begin
				if (gv_q)
					isn_d = (grp_q == CODE_I) || (gjk_q ? 1'b0 : isn_q && grp_q == CODE_J);
				// Pair flag already says an idle group came just before J
				if (gv_q && gjk_q && al_q)
				begin
					push_v = 1'b1;
					st_d = ST_PRE2;
				end
			end
			ST_PRE2:
			begin
				// Second preamble nibble waits here while the buffer is full
				push_v = 1'b1;
				if (in_ready)
					st_d = ST_DATA;
			end
			ST_DATA:
			begin
				if (gv_q)
				begin
					if (grp_q == CODE_T)
						st_d = ST_END;
					else if (grp_q == CODE_I && isn_q)
						st_d = ST_IDLE;
					else
					begin
						push_v = 1'b1;
						push_data.er = !dcd[4];
						push_data.nib = dcd[4] ? dcd[3:0] : ERR_NIB;
					end
					isn_d = (grp_q == CODE_I);
				end
			end
			ST_END:
			begin
				if (gv_q)
				begin
					if (grp_q == CODE_R)
						st_d = ST_IDLE;
					else
					begin
						// Broken end pair: report the lone T as an error
						push_v = 1'b1;
						push_data = '{er: 1'b1, nib: ERR_NIB};
						st_d = ST_DATA;
					end
					isn_d = 1'b0;
				end
			end
			default:
				st_d = ST_IDLE;
		endcase
		// The line cannot be paused, so a full buffer costs a nibble
		ov_d = ov_q || (push_v && !in_ready && st_q != ST_PRE2);
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n || !link_q)
		begin
			st_q <= ST_IDLE;
			isn_q <= 1'b0;
			ov_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			isn_q <= isn_d;
			ov_q <= ov_d;
		end
	end

	// ====================================================================
	// Nibble buffer toward the MII
	fe_fifo #(
		.W($bits(fe_nib_t)),
		.DEPTH(DEPTH)
	) u_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.in_valid(push_v),
		.in_ready(in_ready),
		.in_data(push_data),
		.out_valid(mii_rx_dv),
		.out_ready(mii_ready),
		.out_data(out_data)
	);

	assign mii_rxd = out_data.nib;
	assign mii_rx_er = out_data.er && mii_rx_dv;
	assign rx_active = (st_q != ST_IDLE);
	assign signal_detect = sd_ok_q;
	assign link_up = link_q;
	assign tx_pcs_en = link_q;
	assign rx_pcs_en = link_q;
	assign descr_locked = lock_q;
	assign rx_overflow = ov_q;

	// ====================================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_lvl_hold;
		sym_valid && sym_level == lvl_q |=> nrzi_q == $past(nrzi_q);
	endproperty
	a_lvl_hold: assert property (p_lvl_hold) else $error("NRZI moved without level change");

	property p_lock;
		$rose(lock_q) |-> $past(ones_q) == 7'h3b && hold_q == HOLD_CYC_P - 16'h0001;
	endproperty
	a_lock: assert property (p_lock) else $error("Lock without sixty ones");

	property p_hold_run;
		lock_q && !$rose(lock_q) && $past(lock_q) && !$past(b1_v_q) |-> hold_q == $past(hold_q) - 16'h0001;
	endproperty
	a_hold_run: assert property (p_hold_run) else $error("Hold timer not counting");

	property p_expire;
		lock_q && hold_q == 16'h0000 && link_q |=> !lock_q && lfsr_q == '0;
	endproperty
	a_expire: assert property (p_expire) else $error("Lock kept after hold expiry");

	property p_align;
		jk_hit && link_q |=> al_q && bc_q == 3'h0 && gv_q &&
			gjk_q == $past(win_d[14:10] == CODE_I);
	endproperty
	a_align: assert property (p_align) else $error("Pair did not fix boundary");

	sequence s_pair;
		st_q == ST_IDLE && gv_q && gjk_q && al_q && in_ready && link_q;
	endsequence
	sequence s_pre2;
		st_q == ST_PRE2 && push_v && push_data.nib == PRE_NIB;
	endsequence
	property p_pre;
		s_pair |-> push_v && push_data.nib == PRE_NIB ##1 s_pre2;
	endproperty
	a_pre: assert property (p_pre) else $error("Missing preamble pair");

	property p_ctrl_err;
		st_q == ST_DATA && gv_q && (grp_q == CODE_J || grp_q == CODE_K) |-> push_v && push_data.er;
	endproperty
	a_ctrl_err: assert property (p_ctrl_err) else $error("Control group not flagged");

	property p_sd_run;
		$rose(sd_ok_q) |-> $past(sd_sync_q, 1) && $past(sd_sync_q, 8) && $past(sdc_q) == 6'h27;
	endproperty
	a_sd_run: assert property (p_sd_run) else $error("Detect raised by short burst");

	property p_link_up;
		$rose(link_q) |-> $past(lnk_q) == LINK_CYC_P - 16'h0001 && $past(sd_ok_q);
	endproperty
	a_link_up: assert property (p_link_up) else $error("Link up too early");

	property p_link_down;
		!sd_ok_q |=> !link_q && lnk_q == '0;
	endproperty
	a_link_down: assert property (p_link_down) else $error("Link kept after detect loss");

endmodule : fe_rx_path

`default_nettype wire

/* verif/fe_link_partner.sv */
// Purpose: Remote link partner model driving equalized line symbols
// Assumes: One line bit per valid cycle, sequence x^11+x^9+1
// Notes:   Sends idle whenever its group queue is empty
`default_nettype none

module fe_link_partner
	import fe_pkg::*;
(
	input wire logic clk,
	input wire logic scr_en,
	input wire logic gaps,
	output logic sym_valid,
	output var fe_pkg::fe_lvl_t sym_level
);
	timeunit 1ns;
	timeprecision 1ns;
	// ====================================================================
	// State
	logic [4:0] q [$]; // Groups waiting to go out, first bit is MSB
	logic [4:0] grp = CODE_I; // Group being sent
	int bi = 5; // Bit index inside group
	logic [10:0] seq_q = 11'h5a5; // Arbitrary nonzero seed
	logic [1:0] ph = 2'h0; // Position on the three-level cycle
	logic nb; // Sequence bit
	logic sd; // Scrambled bit
	initial
	begin
		sym_valid = 1'b0;
		sym_level = LVL_ZERO;
	end
	// Transmit one bit per valid cycle; gaps show a changing level
	always @(negedge clk)
	begin
		if (gaps && ($urandom % 4 == 0))
		begin
			// Idle cycle: level is not meaningful, keep it moving
			sym_valid <= 1'b0;
			sym_level <= (sym_level == LVL_POS) ? LVL_NEG : LVL_POS;
		end
		else
		begin
			if (bi == 5)
			begin
				grp = (q.size() > 0) ? q.pop_front() : CODE_I;
				bi = 0;
			end
			// Sequence runs even unscrambled, so lock survives a bypass shorter than the hold countdown
			nb = seq_q[10] ^ seq_q[8];
			seq_q = {seq_q[9:0], nb};
			sd = grp[4 - bi] ^ (nb & scr_en);
			bi++;
			// A one moves the line to the next level
			ph = ph + 2'(sd);
			sym_valid <= 1'b1;
			sym_level <= ph[0] ? (ph[1] ? LVL_NEG : LVL_POS) : LVL_ZERO;
		end
	end
endmodule : fe_link_partner

`default_nettype wire

/* verif/test_fe_rx_path.sv */
// Purpose: Self-checking bench for the receive coding path
// Assumes: Short hold and link counts set by parameter
// Notes:   Random ready and line gaps from a fixed seed
`default_nettype none

module test_fe_rx_path;
	timeunit 1ns;
	timeprecision 1ns;
	import fe_pkg::*;
	// ====================================================================
	// Signals
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic sig_energy = 1'b0;
	logic descr_bypass = 1'b0;
	logic mii_ready = 1'b0;
	logic scr_en = 1'b1; // Partner scrambles
	logic gaps = 1'b0; // Partner leaves gaps
	logic chk_rdy = 1'b0; // Monitor drains
	logic chk_en = 1'b1; // Monitor compares
	logic sd_seen = 1'b0; // Detect seen during pulse test
	logic sym_valid;
	fe_lvl_t sym_level;
	logic mii_rx_dv, mii_rx_er, rx_active, signal_detect, link_up;
	logic tx_pcs_en, rx_pcs_en, descr_locked, rx_overflow;
	logic [3:0] mii_rxd;
	int bad_count = 0;
	int compares = 0;
	int pops = 0; // Nibbles taken
	int lock_low = 0; // Cycles without lock
	logic [4:0] exp_q [$]; // Expected er and nibble
	localparam logic [4:0] ENC [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e,
		5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
	// Idle, pair, then J, invalid, halt and one idle inside data
	localparam logic [4:0] CTL [8] = '{CODE_I, CODE_I, CODE_J, CODE_K, CODE_J, 5'h00, 5'h04,
		CODE_I};
	always #25 clk = ~clk;
	// ====================================================================
	// Design and partner
	fe_rx_path #(.HOLD_CYC_P(16'd400), .LINK_CYC_P(16'd50), .DEPTH(32)) fe_rx_path_inst (
		.clk(clk), .rstn(rstn), .sym_valid(sym_valid), .sym_level(sym_level),
		.sig_energy(sig_energy), .descr_bypass(descr_bypass), .mii_ready(mii_ready),
		.mii_rx_dv(mii_rx_dv), .mii_rxd(mii_rxd), .mii_rx_er(mii_rx_er),
		.rx_active(rx_active), .signal_detect(signal_detect), .link_up(link_up),
		.tx_pcs_en(tx_pcs_en), .rx_pcs_en(rx_pcs_en), .descr_locked(descr_locked),
		.rx_overflow(rx_overflow));
	fe_link_partner fe_link_partner_inst (.clk(clk), .scr_en(scr_en), .gaps(gaps),
		.sym_valid(sym_valid), .sym_level(sym_level));
	// ====================================================================
	// Checking helpers
	function automatic logic [4:0] enc(input logic [3:0] n);
		return ENC[n];
	endfunction : enc
	task automatic check(input logic [4:0] got, input logic [4:0] want);
		compares++;
		if (got !== want)
		begin
			bad_count++;
			$display("mismatch at %0t: got %h want %h", $time, got, want);
		end
	endtask : check
	task automatic report_and_stop;
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop
	// Frame of n data nibbles, random or counting up from zero
	task automatic frame(input int n, input bit all);
		logic [3:0] d;
		// Twelve idles restart the hold timer before every frame
		repeat (12) fe_link_partner_inst.q.push_back(CODE_I);
		fe_link_partner_inst.q.push_back(CODE_J);
		fe_link_partner_inst.q.push_back(CODE_K);
		exp_q.push_back({1'b0, PRE_NIB});
		exp_q.push_back({1'b0, PRE_NIB});
		for (int i = 0; i < n; i++)
		begin
			d = all ? 4'(i) : 4'($urandom);
			fe_link_partner_inst.q.push_back(enc(d));
			exp_q.push_back({1'b0, d});
		end
		fe_link_partner_inst.q.push_back(CODE_T);
		fe_link_partner_inst.q.push_back(CODE_R);
	endtask : frame
	// Bounded wait until every expected nibble came out
	task automatic drain;
		for (int i = 0; i < 4000 && exp_q.size() > 0; i++)
			@(negedge clk);
		check(5'(exp_q.size() != 0), 5'h00);
	endtask : drain
	// ====================================================================
	// MII side: random ready, compare each nibble taken
	always @(negedge clk)
		mii_ready <= chk_rdy && ($urandom % 4 != 0);
	always @(posedge clk)
	begin
		if (signal_detect === 1'b1)
			sd_seen <= 1'b1;
		if (descr_locked !== 1'b1)
			lock_low++;
		if (mii_rx_dv === 1'b1 && mii_ready)
		begin
			pops++;
			if (chk_en && exp_q.size() == 0)
				check({mii_rx_er, mii_rxd}, 5'h1f);
			else if (chk_en)
				check({mii_rx_er, mii_rxd}, exp_q.pop_front());
		end
	end
	// Watchdog well beyond the expected run
	initial
	begin
		#2000000;
		bad_count++;
		report_and_stop();
	end
	// ====================================================================
	// Main sequence
	initial
	begin
		void'($urandom(32'h89de));
		repeat (6) @(negedge clk);
		check(5'({link_up, mii_rx_dv, descr_locked}), 5'h00);
		rstn = 1'b1;
		// Short energy bursts like link pulses never qualify
		repeat (5)
		begin
			sig_energy = 1'b1;
			repeat (20) @(negedge clk);
			sig_energy = 1'b0;
			repeat (30) @(negedge clk);
		end
		check(5'(sd_seen), 5'h00);
		// Steady energy brings the link up after the count
		sig_energy = 1'b1;
		repeat (85) @(negedge clk);
		check(5'(link_up), 5'h00);
		repeat (14) @(negedge clk);
		check(5'({link_up, tx_pcs_en, rx_pcs_en}), 5'h07);
		repeat (40) @(negedge clk);
		check(5'(descr_locked), 5'h00);
		for (int i = 0; i < 300 && descr_locked !== 1'b1; i++)
			@(negedge clk);
		check(5'(descr_locked), 5'h01);
		// Frames with gaps and random ready
		lock_low = 0;
		gaps = 1'b1;
		chk_rdy = 1'b1;
		frame(16, 1'b1);
		repeat (3) frame(6 + $urandom % 10, 1'b0);
		drain();
		// Control and invalid groups inside data, two idles end
		foreach (CTL[i])
			fe_link_partner_inst.q.push_back(CTL[i]);
		exp_q = '{5'h05, 5'h05, 5'h1e, 5'h1e, 5'h1e, 5'h1e};
		drain();
		repeat (1000) @(negedge clk);
		check(5'(lock_low != 0), 5'h00);
		// Long data run without idle: lock drops, then returns
		chk_en = 1'b0;
		frame(100, 1'b0);
		for (int i = 0; i < 1500 && descr_locked !== 1'b0; i++)
			@(negedge clk);
		check(5'(descr_locked), 5'h00);
		for (int i = 0; i < 1500 && descr_locked !== 1'b1; i++)
			@(negedge clk);
		check(5'(descr_locked), 5'h01);
		repeat (100) @(negedge clk);
		exp_q.delete();
		chk_en = 1'b1;
		// Bypass: plain NRZ reaches the aligner
		scr_en = 1'b0;
		descr_bypass = 1'b1;
		repeat (100) @(negedge clk);
		frame(8, 1'b0);
		drain();
		// Leaving bypass may cost one hold period and a relock
		chk_en = 1'b0;
		descr_bypass = 1'b0;
		scr_en = 1'b1;
		repeat (1000) @(negedge clk);
		// Stalled drain fills the buffer until it refuses
		chk_en = 1'b0;
		chk_rdy = 1'b0;
		frame(40, 1'b0);
		repeat (500) @(negedge clk);
		check(5'({rx_overflow, mii_rx_dv}), 5'h03);
		pops = 0;
		chk_rdy = 1'b1;
		for (int i = 0; i < 500 && mii_rx_dv !== 1'b0; i++)
			@(negedge clk);
		check(5'(pops / 2), 5'((FIFO_DEPTH + 1) / 2));
		check(5'(pops % 2), 5'((FIFO_DEPTH + 1) % 2));
		// Loss of energy drops the link at once
		sig_energy = 1'b0;
		repeat (5) @(negedge clk);
		check(5'({signal_detect, link_up, tx_pcs_en, rx_pcs_en, rx_overflow}), 5'h00);
		check(5'(descr_locked), 5'h00);
		report_and_stop();
	end
endmodule : test_fe_rx_path

`default_nettype wire
